/* File: rtl/sbs_port.sv */
module sbs_port #(
  parameter int DATA_W     = sbs_pkg::DATA_W,
  parameter int LANES      = sbs_pkg::LANES,
  parameter int ADDR_W     = sbs_pkg::ADDR_W,
  parameter int FIFO_DEPTH = sbs_pkg::FIFO_DEPTH
) (
  input  wire logic              mclk,
  input  wire logic              arst_n,
  input  wire logic              captureEdgePos,
  input  wire logic              captureEdgeNeg,
  input  wire logic              outputTimingPos,
  input  wire logic              outputTimingNeg,
  input  wire logic              readSelectN,
  input  wire logic              writeSelectN,
  input  wire logic [ADDR_W-1:0] addressIn,
  input  wire logic [LANES-1:0]  byteWriteN,
  input  wire logic [DATA_W-1:0] writeDataBus,
  output logic      [DATA_W-1:0] readDataBus,
  output logic                   echoStrobePos,
  output logic                   echoStrobeNeg,
  output logic                   singleClockMode
);

  localparam int LANE_W = DATA_W / LANES;   // Bits per byte lane
  localparam int WORDS  = (1 << ADDR_W) * sbs_pkg::BURST_LEN;
  localparam int IDX_W  = ADDR_W + 1;       // Burst address plus beat bit
  localparam int NB     = sbs_pkg::WBUF_DEPTH;

  // Bit positions in the control synchroniser
  localparam int B_KP = 0;
  localparam int B_KN = 1;
  localparam int B_CP = 2;
  localparam int B_CN = 3;
  localparam int B_RD = 4;
  localparam int B_WR = 5;
  // Idle level of every control pin; the inverted clocks idle high, so resetting
  // their stages low would fake a rising edge right after reset
  localparam logic [5:0] CTL_IDLE = {sbs_pkg::SEL_IDLE_N, sbs_pkg::SEL_IDLE_N,
                                     ~sbs_pkg::CLK_IDLE, sbs_pkg::CLK_IDLE,
                                     ~sbs_pkg::CLK_IDLE, sbs_pkg::CLK_IDLE};

  // Reset synchroniser
  logic rstMeta;                            // First stage, read only by rstN
  logic rstN;                               // Released copy of arst_n

  // Pin synchronisers, two stages each
  logic [5:0]        ctlMeta;               // Clocks and selects, stage one
  logic [5:0]        ctlSync;               // Clocks and selects, stage two
  logic [5:0]        ctlPrev;               // Previous synced level for edges
  logic [ADDR_W-1:0] addrMeta;
  logic [ADDR_W-1:0] addrSync;
  logic [LANES-1:0]  laneMeta;
  logic [LANES-1:0]  laneSync;
  logic [DATA_W-1:0] dataMeta;
  logic [DATA_W-1:0] dataSync;

  // Edge strobes, one mclk wide
  logic kRise;                              // Input clock rising
  logic knRise;                             // Inverted input clock rising
  logic cRise;                              // Output clock rising
  logic cnRise;                             // Inverted output clock rising
  logic opRise;                             // Selected output timing, positive phase
  logic opnRise;                            // Selected output timing, negative phase

  // Single-clock detection
  logic [sbs_pkg::HOLD_W-1:0] highCount;    // Cycles both output clocks seen high

  // Write capture
  logic              wrArmed;               // First beat taken, waiting for K#
  logic [DATA_W-1:0] wrBeat0;               // First write beat
  logic [LANES-1:0]  wrLane0;               // Lane enables of first beat, active high

  // Write buffer, entry 0 newest
  logic              wbValid [NB];
  logic [ADDR_W-1:0] wbAddr  [NB];
  logic [DATA_W-1:0] wbData  [NB][2];
  logic [LANES-1:0]  wbLane  [NB][2];
  logic              wbPush;                // Complete write enters the buffer

  // Memory array in flip-flops
  logic [DATA_W-1:0] memArray [WORDS];

  // Read scheduling
  logic              rdPend;                // Read taken, waiting for first neg-phase edge
  logic              rdStage;               // Read due at the next neg-phase edge
  logic              beat1Due;              // Second beat due at next pos-phase edge
  logic [ADDR_W-1:0] beatAddr;              // Burst address now being returned
  logic              rdAccept;              // Read command taken this cycle

  // Address FIFO between command capture and output
  logic              fifoInReady;
  logic              fifoOutValid;
  logic [ADDR_W-1:0] fifoOutAddr;
  logic              fifoPop;

  // Reset release through two flip-flops
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      rstMeta <= 1'b0;
      rstN    <= 1'b0;
    end else begin
      rstMeta <= 1'b1;
      rstN    <= rstMeta;
    end
  end

  // Control pins cross into mclk; stage one feeds only stage two
  always_ff @(posedge mclk or negedge rstN) begin
    if (!rstN) begin
      ctlMeta <= CTL_IDLE;
      ctlSync <= CTL_IDLE;
      ctlPrev <= CTL_IDLE;
    end else begin
      // Selects stay active low here, matching their idle reset level
      ctlMeta <= {writeSelectN, readSelectN, outputTimingNeg, outputTimingPos,
                  captureEdgeNeg, captureEdgePos};
      ctlSync <= ctlMeta;
      ctlPrev <= ctlSync;
    end
  end

  // Buses cross with the same two-stage delay so they stay aligned to the clocks
  always_ff @(posedge mclk) begin
    addrMeta <= addressIn;
    addrSync <= addrMeta;
    laneMeta <= byteWriteN;
    laneSync <= laneMeta;
    dataMeta <= writeDataBus;
    dataSync <= dataMeta;
  end

  // Rising edges of each sampled clock
  assign kRise  = ctlSync[B_KP] & ~ctlPrev[B_KP];
  assign knRise = ctlSync[B_KN] & ~ctlPrev[B_KN];
  assign cRise  = ctlSync[B_CP] & ~ctlPrev[B_CP];
  assign cnRise = ctlSync[B_CN] & ~ctlPrev[B_CN];

  assign opRise  = singleClockMode ? kRise  : cRise;
  assign opnRise = singleClockMode ? knRise : cnRise;

  // Both output clocks high for a whole link period means they are tied high;
  // a shorter overlap is only skew between two toggling clocks
  always_ff @(posedge mclk or negedge rstN) begin
    if (!rstN) begin
      highCount       <= '0;
      singleClockMode <= 1'b0;
    end else if (ctlSync[B_CP] && ctlSync[B_CN]) begin
      if (highCount == sbs_pkg::HOLD_W'(sbs_pkg::SINGLE_HOLD_CYC)) begin
        singleClockMode <= 1'b1;
      end else begin
        highCount <= highCount + 1'b1;
      end
    end else begin
      // Any low level means the output clocks are running
      highCount       <= '0;
      singleClockMode <= 1'b0;
    end
  end

  // Echo strobes follow the selected output clocks, free running, stage-aligned with data
  always_ff @(posedge mclk or negedge rstN) begin
    if (!rstN) begin
      echoStrobePos <= sbs_pkg::CLK_IDLE;
      echoStrobeNeg <= sbs_pkg::CLK_IDLE;
    end else begin
      echoStrobePos <= singleClockMode ? ctlSync[B_KP] : ctlSync[B_CP];
      echoStrobeNeg <= singleClockMode ? ctlSync[B_KN] : ctlSync[B_CN];
    end
  end

  // First write beat and its lanes are taken with the write command at K rise
  always_ff @(posedge mclk or negedge rstN) begin
    if (!rstN) begin
      wrArmed <= 1'b0;
      wrBeat0 <= '0;
      wrLane0 <= '0;
    end else if (kRise) begin
      // every K rise may start one
      wrArmed <= ~ctlSync[B_WR];
      if (!ctlSync[B_WR]) begin
        wrBeat0 <= dataSync;
        wrLane0 <= ~laneSync;
      end
    end else if (knRise) begin
      // Write completes at the following K#, one buffer entry per burst
      wrArmed <= 1'b0;
    end
  end

  assign wbPush = knRise & wrArmed;

  // Buffer shifts on each completed write; the oldest entry falls into the array,
  // so a burst reaches the array on the third write cycle, its own counted first
  always_ff @(posedge mclk or negedge rstN) begin
    if (!rstN) begin
      for (int e = 0; e < NB; e++) begin
        wbValid[e]   <= 1'b0;
        wbAddr[e]    <= '0;
        wbData[e][0] <= '0;
        wbData[e][1] <= '0;
        wbLane[e][0] <= '0;
        wbLane[e][1] <= '0;
      end
    end else if (wbPush) begin
      for (int e = NB - 1; e > 0; e--) begin
        wbValid[e] <= wbValid[e-1];
        wbAddr[e]  <= wbAddr[e-1];
        wbData[e]  <= wbData[e-1];
        wbLane[e]  <= wbLane[e-1];
      end
      wbValid[0]   <= 1'b1;
      wbAddr[0]    <= addrSync;
      wbData[0][0] <= wrBeat0;
      wbData[0][1] <= dataSync;
      wbLane[0][0] <= wrLane0;
      wbLane[0][1] <= ~laneSync;
    end
  end

  // Array commit of the oldest buffered burst, lane by lane
  always_ff @(posedge mclk) begin
    if (wbPush && wbValid[NB-1]) begin
      for (int b = 0; b < sbs_pkg::BURST_LEN; b++) begin
        for (int l = 0; l < LANES; l++) begin
          if (wbLane[NB-1][b][l]) begin
            // beat b at base plus b
            memArray[{wbAddr[NB-1], 1'(b)}][l*LANE_W +: LANE_W] <= wbData[NB-1][b][l*LANE_W +: LANE_W];
          end
        end
      end
    end
  end

  // Read word assembled from the array, then overlaid by older and newer buffer entries
  function automatic logic [DATA_W-1:0] fetchWord(input logic [ADDR_W-1:0] addr, input logic beat);
    logic [DATA_W-1:0] word;
    word = memArray[{addr, beat}];
    for (int e = NB - 1; e >= 0; e--) begin
      if (wbValid[e] && (wbAddr[e] == addr)) begin
        for (int l = 0; l < LANES; l++) begin
          if (wbLane[e][beat][l]) begin
            word[l*LANE_W +: LANE_W] = wbData[e][beat][l*LANE_W +: LANE_W];
          end
        end
      end
    end
    return word;
  endfunction

  assign rdAccept = kRise & ~ctlSync[B_RD] & fifoInReady;

  // Read addresses wait here until their beats are due
  sbs_fifo #(
    .WIDTH (ADDR_W),
    .DEPTH (FIFO_DEPTH)
  ) u_rdFifo (
    .clk      (mclk),
    .rstN     (rstN),
    .inValid  (rdAccept),
    .inReady  (fifoInReady),
    .inData   (addrSync),
    .outValid (fifoOutValid),
    .outReady (fifoPop),
    .outData  (fifoOutAddr)
  );

  // Oldest address leaves when its first beat goes out
  assign fifoPop = opnRise & rdStage;

  // Read latency: first neg-phase edge after the command arms, the second one drives
  always_ff @(posedge mclk or negedge rstN) begin
    if (!rstN) begin
      rdPend  <= 1'b0;
      rdStage <= 1'b0;
    end else begin
      if (opnRise) begin
        // beat due on second neg edge
        rdStage <= rdPend | rdAccept;
        rdPend  <= 1'b0;
      end else if (rdAccept) begin
        rdPend <= 1'b1;
      end
    end
  end

  // Beat output register, holds between updates
  always_ff @(posedge mclk or negedge rstN) begin
    if (!rstN) begin
      readDataBus <= '0;
      beat1Due    <= 1'b0;
      beatAddr    <= '0;
    end else if (opnRise && rdStage && fifoOutValid) begin
      readDataBus <= fetchWord(fifoOutAddr, 1'b0);
      beatAddr    <= fifoOutAddr;
      beat1Due    <= 1'b1;
    end else if (opRise && beat1Due) begin
      // second beat on next pos edge
      // second beat addresses base plus one
      readDataBus <= fetchWord(beatAddr, 1'b1);
      beat1Due    <= 1'b0;
    end
  end

endmodule

/* File: rtl/sbs_pkg.sv */
// Shared constants for the burst-of-two separate-port SRAM port logic
package sbs_pkg;

  // Data bus width and its byte lanes
  localparam int DATA_W          = 36;
  localparam int LANES           = 4;
  // Burst address width (array index adds one beat bit)
  localparam int ADDR_W          = 4;
  // Fixed burst length, never programmable
  localparam int BURST_LEN       = 2;
  // Depth of the pending-read address FIFO
  localparam int FIFO_DEPTH      = 16;
  // Write buffer entries before an array commit
  localparam int WBUF_DEPTH      = 2;
  // Synchroniser length for every pin input
  localparam int SYNC_STAGES     = 2;

  // System clock period and the link clock period it samples
  localparam int MCLK_NS         = 25;
  localparam int LINK_PERIOD_NS  = 200;
  // Cycles with both output clocks high before single-clock mode is taken (least time, rounded up)
  localparam int SINGLE_HOLD_CYC = (LINK_PERIOD_NS + MCLK_NS - 1) / MCLK_NS;
  localparam int HOLD_W          = 4;

  // Values after reset
  localparam logic SEL_IDLE_N    = 1'b1;
  localparam logic CLK_IDLE      = 1'b0;

endpackage

/* File: rtl/sbs_fifo.sv */
// Pending-read address FIFO, flip-flop storage, valid/ready on both sides
module sbs_fifo #(
  parameter int WIDTH = 4,
  parameter int DEPTH = 16
) (
  input  wire logic             clk,
  input  wire logic             rstN,
  input  wire logic             inValid,
  output logic                  inReady,
  input  wire logic [WIDTH-1:0] inData,
  output logic                  outValid,
  input  wire logic             outReady,
  output logic      [WIDTH-1:0] outData
);

  localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

  logic [WIDTH-1:0] store [DEPTH];   // Entry storage
  logic [AW-1:0]    wrPtr;           // Next slot to fill
  logic [AW-1:0]    rdPtr;           // Oldest slot
  logic [AW:0]      count;           // Entries held
  logic             doPush;
  logic             doPop;

  // Honest full and empty flags
  assign inReady  = (count != (AW+1)'(DEPTH));
  assign outValid = (count != '0);
  assign outData  = store[rdPtr];
  assign doPush   = inValid & inReady;
  assign doPop    = outValid & outReady;

  // Storage write, no reset needed on data
  always_ff @(posedge clk) begin
    if (doPush) begin
      store[wrPtr] <= inData;
    end
  end

  // Pointers wrap at the parameter depth
  always_ff @(posedge clk or negedge rstN) begin
    if (!rstN) begin
      wrPtr <= '0;
      rdPtr <= '0;
    end else begin
      if (doPush) begin
        wrPtr <= (wrPtr == AW'(DEPTH - 1)) ? '0 : wrPtr + 1'b1;
      end
      if (doPop) begin
        rdPtr <= (rdPtr == AW'(DEPTH - 1)) ? '0 : rdPtr + 1'b1;
      end
    end
  end

  // Occupancy follows push and pop together
  always_ff @(posedge clk or negedge rstN) begin
    if (!rstN) begin
      count <= '0;
    end else begin
      case ({doPush, doPop})
        2'b10:   count <= count + 1'b1;
        2'b01:   count <= count - 1'b1;
        default: count <= count;
      endcase
    end
  end

endmodule

/* File: sim/sbs_port_assertions.sv */
// Checker on the port pins: echo strobes, clock mode and read output timing
module sbs_port_checker #(
  parameter int DATA_W = 36
) (
  input wire logic              mclk,
  input wire logic              arst_n,
  input wire logic              captureEdgePos,
  input wire logic              captureEdgeNeg,
  input wire logic              outputTimingPos,
  input wire logic              outputTimingNeg,
  input wire logic              readSelectN,
  input wire logic [DATA_W-1:0] readDataBus,
  input wire logic              echoStrobePos,
  input wire logic              echoStrobeNeg,
  input wire logic              singleClockMode
);
  logic [3:0] upCnt;  // Cycles since reset release
  logic [3:0] hiCnt;  // Cycles with both output clocks high
  logic [5:0] rdIdle; // Cycles since read select was last low

  default clocking @(posedge mclk); endclocking
  default disable iff (!arst_n);

  // Masks the synchroniser fill after reset, which would look like a stale echo
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) upCnt <= 4'h0;
    else if (upCnt != 4'hf) upCnt <= upCnt + 4'h1;
  end

  // Saturating count of both output clocks held high
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) hiCnt <= 4'h0;
    else if (!(outputTimingPos && outputTimingNeg)) hiCnt <= 4'h0;
    else if (hiCnt != 4'hf) hiCnt <= hiCnt + 4'h1;
  end

  // Saturating count of read-idle cycles
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) rdIdle <= 6'h00;
    else if (!readSelectN) rdIdle <= 6'h00;
    else if (rdIdle != 6'h3f) rdIdle <= rdIdle + 6'h01;
  end

  chk_echo_pos_single: assert property (
    upCnt == 4'hf && singleClockMode && $past(singleClockMode, 4) |-> echoStrobePos == $past(captureEdgePos, 3)
  ) else $error("positive echo does not track input clock");
  chk_echo_neg_single: assert property (
    upCnt == 4'hf && singleClockMode && $past(singleClockMode, 4) |-> echoStrobeNeg == $past(captureEdgeNeg, 3)
  ) else $error("negative echo does not track input clock");
  chk_echo_pos_dual: assert property (
    upCnt == 4'hf && !singleClockMode && !$past(singleClockMode, 4) |-> echoStrobePos == $past(outputTimingPos, 3)
  ) else $error("positive echo does not track output clock");
  chk_mode_needs_hold: assert property (
    $rose(singleClockMode) |-> hiCnt >= 4'h9
  ) else $error("single clock mode taken too early");
  chk_mode_dropped: assert property (
    !outputTimingPos [*4] |-> ##[0:6] !singleClockMode
  ) else $error("single clock mode kept with output clock low");
  chk_data_on_echo: assert property (
    upCnt == 4'hf && $changed(readDataBus) |-> $rose(echoStrobePos) || $rose(echoStrobeNeg)
  ) else $error("read data changed off an echo edge");
  chk_first_beat_gap: assert property (
    $fell(readSelectN) && rdIdle >= 6'h14 && singleClockMode |=> $stable(readDataBus) [*8]
  ) else $error("read data moved too soon after command");
  chk_quiet_idle: assert property (
    rdIdle >= 6'h28 |-> $stable(readDataBus)
  ) else $error("read data moved with no read pending");
endmodule

bind sbs_port sbs_port_checker #(.DATA_W(DATA_W)) portChk (
  .mclk(mclk), .arst_n(arst_n), .captureEdgePos(captureEdgePos), .captureEdgeNeg(captureEdgeNeg),
  .outputTimingPos(outputTimingPos), .outputTimingNeg(outputTimingNeg), .readSelectN(readSelectN),
  .readDataBus(readDataBus), .echoStrobePos(echoStrobePos), .echoStrobeNeg(echoStrobeNeg),
  .singleClockMode(singleClockMode)
);

/* File: sim/sbs_ctrl_model.sv */
// Memory controller model: makes the input clock pair and issues commands
module sbs_ctrl_model (
  input  wire logic                        single,
  output logic                             captureEdgePos,
  output logic                             captureEdgeNeg,
  output logic                             outputTimingPos,
  output logic                             outputTimingNeg,
  output logic                             readSelectN,
  output logic                             writeSelectN,
  output logic [sbs_pkg::ADDR_W-1:0]       addressIn,
  output logic [sbs_pkg::LANES-1:0]        byteWriteN,
  output logic [sbs_pkg::DATA_W-1:0]       writeDataBus
);
  timeunit 1ns;
  timeprecision 100ps;

  // Output clocks follow the input pair, or sit high for single-clock mode
  assign outputTimingPos = single | captureEdgePos;
  assign outputTimingNeg = single | captureEdgeNeg;

  // Clock stands still between calls
  initial begin
    captureEdgePos = 1'b0;
    captureEdgeNeg = 1'b1;
    readSelectN = 1'b1;
    writeSelectN = 1'b1;
    addressIn = '0;
    byteWriteN = '1;
    writeDataBus = '0;
  end

  // One 200 ns link cycle; unused address and data lines get inverted so stale values never match; byte enables are driven as given
  task linkCycle(input logic rdN, input logic [sbs_pkg::ADDR_W-1:0] ra, input logic wrN,
                 input logic [sbs_pkg::ADDR_W-1:0] wa, input logic [sbs_pkg::DATA_W-1:0] d0, d1,
                 input logic [sbs_pkg::LANES-1:0] l0, l1);
    readSelectN = rdN;
    writeSelectN = wrN;
    addressIn = rdN ? ~addressIn : ra;
    writeDataBus = wrN ? ~writeDataBus : d0;
    byteWriteN = l0;
    #50;
    captureEdgePos = 1'b1;
    captureEdgeNeg = 1'b0;
    #50;
    readSelectN = 1'b1;
    writeSelectN = 1'b1;
    addressIn = wrN ? ~addressIn : wa;
    writeDataBus = wrN ? ~writeDataBus : d1;
    byteWriteN = l1;
    #50;
    captureEdgePos = 1'b0;
    captureEdgeNeg = 1'b1;
    #50;
  endtask
endmodule

/* File: sim/sbs_port_test.sv */
// Self-checking bench for the separate-port burst-of-two port logic
module sbs_port_test;
  timeunit 1ns;
  timeprecision 100ps;
  localparam int DW = sbs_pkg::DATA_W;
  localparam int AW = sbs_pkg::ADDR_W;

  logic          mclk, arst_n, single;
  logic          captureEdgePos, captureEdgeNeg, outputTimingPos, outputTimingNeg;
  logic          readSelectN, writeSelectN, echoStrobePos, echoStrobeNeg, singleClockMode;
  logic [AW-1:0] addressIn;
  logic [3:0]    byteWriteN;
  logic [DW-1:0] writeDataBus, readDataBus;
  logic [DW-1:0] mem [2**(AW+1)]; // Expected array contents
  int            err_count, checked;

  sbs_ctrl_model P (.single(single), .captureEdgePos(captureEdgePos), .captureEdgeNeg(captureEdgeNeg),
    .outputTimingPos(outputTimingPos), .outputTimingNeg(outputTimingNeg), .readSelectN(readSelectN),
    .writeSelectN(writeSelectN), .addressIn(addressIn), .byteWriteN(byteWriteN), .writeDataBus(writeDataBus));

  sbs_port DUT (.mclk(mclk), .arst_n(arst_n), .captureEdgePos(captureEdgePos), .captureEdgeNeg(captureEdgeNeg),
    .outputTimingPos(outputTimingPos), .outputTimingNeg(outputTimingNeg), .readSelectN(readSelectN),
    .writeSelectN(writeSelectN), .addressIn(addressIn), .byteWriteN(byteWriteN), .writeDataBus(writeDataBus),
    .readDataBus(readDataBus), .echoStrobePos(echoStrobePos), .echoStrobeNeg(echoStrobeNeg),
    .singleClockMode(singleClockMode));

  // 40 MHz system clock
  initial begin
    mclk = 1'b0;
    forever #12.5 mclk = ~mclk;
  end

  task automatic chk(input logic [DW-1:0] seen, input logic [DW-1:0] exp);
    checked++;
    if (seen !== exp) begin
      err_count++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  // Lanes with a low enable take the new byte
  function automatic logic [DW-1:0] mrg(input logic [DW-1:0] o, n, input logic [3:0] l);
    for (int i = 0; i < 4; i++) begin
      if (!l[i]) o[i*9 +: 9] = n[i*9 +: 9];
    end
    return o;
  endfunction

  task automatic nop();
    P.linkCycle(1'b1, '0, 1'b1, '0, '0, '0, 4'hf, 4'hf);
  endtask

  task automatic wr(input logic [AW-1:0] a, input logic [DW-1:0] d0, d1, input logic [3:0] l0, l1);
    mem[{a, 1'b0}] = mrg(mem[{a, 1'b0}], d0, l0);
    mem[{a, 1'b1}] = mrg(mem[{a, 1'b1}], d1, l1);
    P.linkCycle(1'b1, ~a, 1'b0, a, d0, d1, l0, l1);
  endtask

  // Read, optionally with a full write to the same address, then two idle cycles
  task automatic rd(input logic [AW-1:0] a, input logic wN, input logic [DW-1:0] d0, d1);
    if (!wN) begin
      mem[{a, 1'b0}] = d0;
      mem[{a, 1'b1}] = d1;
    end
    fork
      begin
        P.linkCycle(1'b0, a, wN, a, d0, d1, 4'h0, 4'h0);
        nop();
        nop();
      end
      begin
        #475;
        chk(readDataBus, mem[{a, 1'b0}]);
        #100;
        chk(readDataBus, mem[{a, 1'b1}]);
      end
    join
  endtask

  task automatic modes();
    repeat (4) nop();
    chk(DW'(singleClockMode), '0);
    wr(4'h1, 36'h2_4681_3579, 36'hd_b975_eca8, 4'h0, 4'h0);
    rd(4'h1, 1'b1, '0, '0);
    single = 1'b1;
    repeat (2) nop();
    chk(DW'(singleClockMode), DW'(1));
  endtask

  task automatic writeRead();
    wr(4'h3, 36'h1_2345_6789, 36'h9_8765_4321, 4'h0, 4'h0);
    wr(4'h4, 36'h5_5aa5_0ff0, 36'ha_a55a_f00f, 4'h0, 4'h0);
    rd(4'h3, 1'b1, '0, '0);
    rd(4'h4, 1'b1, '0, '0);
  endtask

  task automatic laneMerge();
    wr(4'h3, 36'hf_ffff_ffff, 36'h0_0000_0000, 4'ha, 4'h5);
    rd(4'h3, 1'b1, '0, '0);
  endtask

  // Back-to-back writes push the buffered burst out, then a deselected write
  task automatic commitOrder();
    for (int i = 5; i < 8; i++) begin
      wr(AW'(i), {4'h6, AW'(i), 28'h0123456}, {4'h9, AW'(i), 28'hfedcba9}, 4'h0, 4'h0);
    end
    P.linkCycle(1'b1, '0, 1'b1, 4'h3, '1, '1, 4'h0, 4'h0);
    rd(4'h3, 1'b1, '0, '0);
    rd(4'h6, 1'b1, '0, '0);
  endtask

  task automatic crossPort();
    rd(4'h9, 1'b0, 36'hc_3c3c_3c3c, 36'h3_c3c3_c3c3);
  endtask

  // Untying the output clocks hands output timing back to them
  task automatic modeReturn();
    single = 1'b0;
    repeat (2) nop();
    chk(DW'(singleClockMode), '0);
    rd(4'h9, 1'b1, '0, '0);
  endtask

  task automatic summarize();
    $display("Comparisons %0d, mismatches %0d", checked, err_count);
    if (err_count == 0 && checked > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  // Cuts a hang short
  initial begin
    #150000;
    err_count++;
    summarize();
  end

  initial begin
    err_count = 0;
    checked = 0;
    single = 1'b0;
    arst_n = 1'b0;
    repeat (12) @(negedge mclk);
    arst_n = 1'b1;
    repeat (8) @(negedge mclk);
    modes();
    writeRead();
    laneMerge();
    commitOrder();
    crossPort();
    modeReturn();
    summarize();
  end
endmodule
